// >>> hdl/fdcpw_defines.svh
// constants for the floppy powerdown and wake controller
// assumes a 200 MHz clock and word-aligned 32-bit register slots
`ifndef FDCPW_DEFINES_SVH
`define FDCPW_DEFINES_SVH

// register indexes, byte address is four times the index
`define FDCPW_IDX_STA 4'h0
`define FDCPW_IDX_STB 4'h1
`define FDCPW_IDX_DOC 4'h2
`define FDCPW_IDX_RSC 4'h4
`define FDCPW_IDX_MST 4'h4
`define FDCPW_IDX_FIFO 4'h5
`define FDCPW_IDX_DIS 4'h7
`define FDCPW_IDX_CFG 4'h7
`define FDCPW_IDX_PWR 4'h8

// digital output control fields
`define FDCPW_DOC_RST_N 2
`define FDCPW_DOC_MOT_LO 4
`define FDCPW_DOC_MOT_HI 7
// rate select control fields
`define FDCPW_RSC_SWRST 7
`define FDCPW_RSC_PD 6
// power control fields
`define FDCPW_PWR_AUTO 0

// reset values and the idle main status value
`define FDCPW_DOC_RST 8'h00
`define FDCPW_RSC_RST 8'h02
`define FDCPW_PWR_RST 8'h00
`define FDCPW_MST_IDLE 8'h80

// auto powerdown timer
`define FDCPW_APD_MS 10
`define FDCPW_CLK_MHZ 200
`define FDCPW_TMR_W 21

`endif

// >>> hdl/fdcpw_pkg.sv
// types for the floppy powerdown and wake controller
// assumes nothing beyond the defines header
package fdcpw_pkg;
    typedef enum logic [1:0] {
        pwr_active,
        pwr_auto,
        pwr_rate
    } fdcpw_pwr_t;
endpackage

// >>> hdl/fdcpw_timer.sv
// auto powerdown timer, counts while run is high
// assumes one clock and restart as a one-cycle pulse
`timescale 1ns/1ps
`include "fdcpw_defines.svh"
module fdcpw_timer #(
    parameter logic [`FDCPW_TMR_W-1:0] COUNT = 21'd2_000_000
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    fdcpw_tmr_if.tmr t
);
    logic [`FDCPW_TMR_W-1:0] cnt_reg;

    // cleared when stopped, so every start is a full period
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else if (t.restart || !t.run) begin
            cnt_reg <= '0;
        end else if (cnt_reg != COUNT) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign t.expired = (cnt_reg == COUNT);
endmodule

// >>> hdl/fdcpw_tmr_if.sv
// link between the controller and its powerdown timer
// assumes both ends share one clock
`timescale 1ns/1ps
interface fdcpw_tmr_if;
    logic restart;
    logic run;
    logic expired;
    modport ctl (output restart, output run, input expired);
    modport tmr (input restart, input run, output expired);
endinterface

// >>> hdl/fdcpw_top.sv
// floppy controller powerdown and wake logic with avalon register slave
// assumes synchronous inputs, core status from the disk controller core
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "fdcpw_defines.svh"

// Summary of operation
// [RULE1] rate select powerdown overrides auto powerdown; auto resumes later
// [RULE2] host reset pin or either software reset bit wakes, full reset
// [RULE3] waking register access resumes prior state, no reinitialisation
// [RULE4] setting a motor enable bit wakes; reading it does not
// [RULE5] any main status read wakes from auto powerdown
// [RULE6] any fifo data read or write wakes from auto powerdown
// [RULE7] after wake the 10 ms timer restarts before next powerdown
// [RULE8] plain output or rate control writes do not wake
// [RULE9] status, digital input and config accesses leave part asleep
// [RULE10] reads while asleep return true current register value
// [RULE11] writes while asleep are kept and applied on wake
// [RULE12] access while asleep raises power briefly then drops again
// [RULE13] system bus side keeps working in auto powerdown
// [RULE14] motor, select, write data and gate pins tristate while asleep
// [RULE15] step, direction, head and density stay driven; inputs still work
// [RULE16] enter auto only: motors off, idle 80h, no int, timers done
// [RULE17] wake and timer expiry together resolve as wake
module fdcpw_top
    import fdcpw_pkg::*;
#(
    parameter logic [`FDCPW_TMR_W-1:0] APD_CYCLES =
        `FDCPW_TMR_W'(`FDCPW_APD_MS * 1000 * `FDCPW_CLK_MHZ)
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // avalon register slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // host reset
    input wire logic host_reset_pin_n,
    // disk controller core
    input wire logic [7:0] core_msr,
    input wire logic core_int,
    input wire logic core_head_unload_done,
    input wire logic [7:0] core_fifo_rdata,
    input wire logic core_wdata_n,
    input wire logic core_wgate_n,
    input wire logic core_step_n,
    input wire logic core_dir_n,
    input wire logic core_hdsel_n,
    output logic core_reset,
    output logic core_fifo_rd,
    output logic core_fifo_wr,
    output logic [7:0] core_fifo_wdata,
    output logic [1:0] core_rate,
    output logic core_clk_en,
    output logic core_powered_down,
    // drive outputs, tristated while asleep
    output logic motor_on_out_n,
    output logic motor_on_oe,
    output logic drive_select_out_n,
    output logic drive_select_oe,
    output logic write_stream_out_n,
    output logic write_stream_oe,
    output logic write_gate_out_n,
    output logic write_gate_oe,
    // drive outputs, always driven
    output logic step_direction_out_n,
    output logic step_pulse_out_n,
    output logic head_side_out_n,
    output logic [1:0] density_select_out,
    // drive status inputs
    input wire logic read_stream_in_n,
    input wire logic write_protect_in_n,
    input wire logic track_zero_in_n,
    input wire logic index_pulse_in_n,
    input wire logic disk_change_in_n
);
    // ****************************************
    // bus slave
    // ****************************************
    fdcpw_pwr_t pwr_reg;
    fdcpw_pwr_t pwr_next;
    logic [7:0] doc_reg;
    logic [1:0] rate_reg;
    logic [7:0] pwr_ctl_reg;
    logic [3:0] idx;
    logic wr_acc;
    logic rd_acc;
    logic wr_lane;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic hw_rst;
    logic sw_rst;
    logic wake;
    logic rate_pd_req;
    logic enter_ok;
    fdcpw_tmr_if tmr_if ();

    assign idx = avs_address[5:2];
    assign wbyte = avs_writedata[7:0];
    assign wr_lane = avs_byteenable[0] && (avs_address[1:0] == 2'b00);
    // access takes effect at the edge where waitrequest is seen low
    assign wr_acc = avs_write && !avs_waitrequest && wr_lane;
    assign rd_acc = avs_read && !avs_waitrequest;

    // one wait state, answered whatever the power state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (!avs_waitrequest) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0; // RULE13
        end
    end

    // true live values in every power state
    always_comb begin
        rd_byte = 8'h00;
        if (avs_address[1:0] == 2'b00) begin
            unique case (idx)
                `FDCPW_IDX_STA: rd_byte = {5'h00, ~track_zero_in_n,
                    ~index_pulse_in_n, ~write_protect_in_n}; // RULE9
                `FDCPW_IDX_STB: rd_byte = {7'h00, ~read_stream_in_n};
                `FDCPW_IDX_DOC: rd_byte = doc_reg; // RULE10
                `FDCPW_IDX_MST: rd_byte = core_msr;
                `FDCPW_IDX_FIFO: rd_byte = core_fifo_rdata;
                `FDCPW_IDX_DIS: rd_byte = {~disk_change_in_n, 7'h00};
                `FDCPW_IDX_PWR: rd_byte = {5'h00, pwr_reg,
                    pwr_ctl_reg[`FDCPW_PWR_AUTO]};
                default: rd_byte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, rd_byte}; // RULE10
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // stored regardless of power state, kept across sleep
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            doc_reg <= `FDCPW_DOC_RST;
            rate_reg <= 2'(`FDCPW_RSC_RST);
            pwr_ctl_reg <= `FDCPW_PWR_RST;
        end else if (hw_rst) begin
            doc_reg <= `FDCPW_DOC_RST; // RULE2
            rate_reg <= 2'(`FDCPW_RSC_RST);
        end else if (wr_acc) begin
            unique case (idx)
                `FDCPW_IDX_DOC: doc_reg <= wbyte; // RULE11
                `FDCPW_IDX_RSC: rate_reg <= wbyte[1:0];
                `FDCPW_IDX_CFG: rate_reg <= wbyte[1:0]; // RULE9
                `FDCPW_IDX_PWR: pwr_ctl_reg <= {7'h00,
                    wbyte[`FDCPW_PWR_AUTO]};
                default: ;
            endcase
        end
    end

    // ****************************************
    // wake and sleep events
    // ****************************************
    assign hw_rst = !host_reset_pin_n;
    assign sw_rst = wr_acc && (
        (idx == `FDCPW_IDX_DOC && !wbyte[`FDCPW_DOC_RST_N]) ||
        (idx == `FDCPW_IDX_RSC && wbyte[`FDCPW_RSC_SWRST])); // RULE2
    assign rate_pd_req = wr_acc && idx == `FDCPW_IDX_RSC &&
        wbyte[`FDCPW_RSC_PD];

    // dor reads and plain control writes are absent here
    assign wake = hw_rst || sw_rst || // RULE8
        (wr_acc && idx == `FDCPW_IDX_DOC &&
            wbyte[`FDCPW_DOC_MOT_HI:`FDCPW_DOC_MOT_LO] != 4'h0) || // RULE4
        (rd_acc && idx == `FDCPW_IDX_MST) || // RULE5
        ((rd_acc || wr_acc) && idx == `FDCPW_IDX_FIFO); // RULE6

    assign enter_ok = pwr_ctl_reg[`FDCPW_PWR_AUTO] &&
        doc_reg[`FDCPW_DOC_MOT_HI:`FDCPW_DOC_MOT_LO] == 4'h0 &&
        core_msr == `FDCPW_MST_IDLE && !core_int &&
        core_head_unload_done && tmr_if.expired; // RULE16

    // ****************************************
    // power state
    // ****************************************
    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            pwr_active: begin
                if (rate_pd_req && !hw_rst && !sw_rst) begin
                    pwr_next = pwr_rate;
                end else if (enter_ok && !wake) begin
                    pwr_next = pwr_auto; // RULE17
                end
            end
            pwr_auto: begin
                if (hw_rst || sw_rst) begin
                    pwr_next = pwr_active;
                end else if (rate_pd_req) begin
                    pwr_next = pwr_rate; // RULE1
                end else if (wake) begin
                    pwr_next = pwr_active; // RULE3
                end
            end
            pwr_rate: begin
                if (hw_rst || sw_rst) begin
                    pwr_next = pwr_active; // RULE1
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_reg <= pwr_active;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // ****************************************
    // powerdown timer
    // ****************************************
    assign tmr_if.restart = wake; // RULE7
    assign tmr_if.run = pwr_ctl_reg[`FDCPW_PWR_AUTO] &&
        pwr_reg == pwr_active;

    fdcpw_timer #(
        .COUNT(APD_CYCLES)
    ) u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .t(tmr_if.tmr)
    );

    // ****************************************
    // core side
    // ****************************************
    // only resets restart the core; waking accesses do not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= hw_rst || sw_rst ||
                !doc_reg[`FDCPW_DOC_RST_N]; // RULE2
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_fifo_rd <= 1'b0;
            core_fifo_wr <= 1'b0;
            core_fifo_wdata <= 8'h00;
        end else begin
            core_fifo_rd <= rd_acc && idx == `FDCPW_IDX_FIFO;
            core_fifo_wr <= wr_acc && idx == `FDCPW_IDX_FIFO;
            if (wr_acc && idx == `FDCPW_IDX_FIFO) begin
                core_fifo_wdata <= wbyte;
            end
        end
    end

    // stored rate reaches the core only while awake
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_rate <= 2'(`FDCPW_RSC_RST);
        end else if (pwr_reg == pwr_active) begin
            core_rate <= rate_reg; // RULE11
        end
    end

    // clock on while awake or while an access is in flight
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_clk_en <= 1'b1;
            core_powered_down <= 1'b0;
        end else begin
            core_clk_en <= pwr_next == pwr_active ||
                avs_read || avs_write; // RULE12
            core_powered_down <= pwr_next != pwr_active;
        end
    end

    // ****************************************
    // drive pins
    // ****************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            motor_on_out_n <= 1'b1;
            drive_select_out_n <= 1'b1;
            write_stream_out_n <= 1'b1;
            write_gate_out_n <= 1'b1;
        end else begin
            motor_on_out_n <= !doc_reg[`FDCPW_DOC_MOT_LO];
            drive_select_out_n <= doc_reg[1:0] != 2'b00;
            write_stream_out_n <= core_wdata_n;
            write_gate_out_n <= core_wgate_n;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            motor_on_oe <= 1'b1;
            drive_select_oe <= 1'b1;
            write_stream_oe <= 1'b1;
            write_gate_oe <= 1'b1;
        end else begin
            motor_on_oe <= pwr_next == pwr_active; // RULE14
            drive_select_oe <= pwr_next == pwr_active;
            write_stream_oe <= pwr_next == pwr_active;
            write_gate_oe <= pwr_next == pwr_active;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_direction_out_n <= 1'b1;
            step_pulse_out_n <= 1'b1;
            head_side_out_n <= 1'b1;
            density_select_out <= 2'b00;
        end else begin
            step_direction_out_n <= core_dir_n; // RULE15
            step_pulse_out_n <= core_step_n;
            head_side_out_n <= core_hdsel_n;
            density_select_out <= core_rate;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_doc_read_sleeps;
        pwr_reg == pwr_auto && rd_acc && idx == `FDCPW_IDX_DOC &&
            !hw_rst |=> pwr_reg == pwr_auto;
    endproperty
    a_doc_read_sleeps: assert property (p_doc_read_sleeps) // RULE4
        else $error("dor read woke the part");

    property p_msr_wakes;
        pwr_reg == pwr_auto && rd_acc && idx == `FDCPW_IDX_MST
            |=> pwr_reg == pwr_active ##1 core_clk_en;
    endproperty
    a_msr_wakes: assert property (p_msr_wakes) // RULE5
        else $error("main status read did not wake");

    property p_fifo_wakes;
        pwr_reg == pwr_auto && (rd_acc || wr_acc) &&
            idx == `FDCPW_IDX_FIFO && !hw_rst
            |=> pwr_reg == pwr_active && !core_reset;
    endproperty
    a_fifo_wakes: assert property (p_fifo_wakes) // RULE6
        else $error("fifo access did not wake cleanly");

    property p_pins_float;
        pwr_next != pwr_active |=> !motor_on_oe && !drive_select_oe &&
            !write_stream_oe && !write_gate_oe;
    endproperty
    a_pins_float: assert property (p_pins_float) // RULE14
        else $error("drive pins driven while asleep");

    property p_rate_holds;
        pwr_reg == pwr_rate && !hw_rst && !sw_rst
            |=> pwr_reg == pwr_rate;
    endproperty
    a_rate_holds: assert property (p_rate_holds) // RULE1
        else $error("rate powerdown left without reset");

    property p_hw_reset;
        hw_rst |=> core_reset && pwr_reg == pwr_active &&
            doc_reg == `FDCPW_DOC_RST;
    endproperty
    a_hw_reset: assert property (p_hw_reset) // RULE2
        else $error("host reset did not reset");

    property p_wake_wins;
        pwr_reg == pwr_active && wake && !rate_pd_req
            |=> pwr_reg == pwr_active;
    endproperty
    a_wake_wins: assert property (p_wake_wins) // RULE17
        else $error("slept in a waking cycle");

    property p_plain_write_sleeps;
        pwr_reg == pwr_auto && wr_acc && idx == `FDCPW_IDX_DOC &&
            wbyte[7:4] == 4'h0 && wbyte[`FDCPW_DOC_RST_N] && !hw_rst
            |=> pwr_reg == pwr_auto;
    endproperty
    a_plain_write_sleeps: assert property (p_plain_write_sleeps) // RULE8
        else $error("plain dor write woke the part");

    property p_entry_cond;
        pwr_reg == pwr_active ##1 pwr_reg == pwr_auto
            |-> $past(tmr_if.expired) && $past(core_msr) == 8'h80 &&
                !$past(core_int);
    endproperty
    a_entry_cond: assert property (p_entry_cond) // RULE16
        else $error("auto powerdown entered too early");

    property p_sleep_clk_off;
        pwr_reg == pwr_auto && !avs_read && !avs_write &&
            !wake |=> !core_clk_en;
    endproperty
    a_sleep_clk_off: assert property (p_sleep_clk_off) // RULE12
        else $error("core clock left on while asleep");

    property p_timer_restart;
        wake |=> !tmr_if.expired [*2];
    endproperty
    a_timer_restart: assert property (p_timer_restart) // RULE7
        else $error("timer not restarted on wake");
endmodule

// >>> tb/fdcpw_host_model.sv
// host side master issuing single byte register accesses
// assumes the bench clock and a slave that ends each wait
`timescale 1ns/1ps
module fdcpw_host_model (
    // clock
    input wire logic clk,
    // avalon master
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    int n_stall;

    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        n_stall = 0;
    end

    // one access, held until waitrequest is sampled low
    task automatic xfer(input logic [3:0] idx, input logic wr,
                        input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h00_0000, wd};
        avs_byteenable <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        // more than the one wait state the slave promises
        if (n > 2) begin
            n_stall++;
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released data no longer shows the last value
        avs_writedata <= ~{24'h00_0000, wd};
        avs_byteenable <= 4'h0;
    endtask
endmodule

// >>> tb/fdcpw_top_tb_top.sv
// bench for the powerdown and wake controller
// assumes the host model and a short powerdown timer
`timescale 1ns/1ps
`include "fdcpw_defines.svh"
module fdcpw_top_tb_top;
    logic clk, arst_n, host_reset_pin_n;
    logic [5:0] adr;
    logic rd_s, wr_s, wq;
    logic [31:0] wd, rdd;
    logic [3:0] be;
    logic [7:0] core_msr, core_fifo_rdata, core_fifo_wdata, v;
    logic core_int, core_head_unload_done, core_wdata_n, core_wgate_n;
    logic core_step_n, core_dir_n, core_hdsel_n, core_reset;
    logic core_fifo_rd, core_fifo_wr, core_clk_en, core_powered_down;
    logic [1:0] core_rate, density_select_out;
    logic motor_on_out_n, motor_on_oe, drive_select_out_n;
    logic drive_select_oe, write_stream_out_n, write_stream_oe;
    logic write_gate_out_n, write_gate_oe;
    logic step_direction_out_n, step_pulse_out_n, head_side_out_n;
    logic read_stream_in_n, write_protect_in_n, track_zero_in_n;
    logic index_pulse_in_n, disk_change_in_n;
    int n_fail, checked;

    // ****************
    // design and host
    // ****************
    fdcpw_top #(.APD_CYCLES(21'd20)) DUT (
        .clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be),
        .avs_readdata(rdd), .avs_waitrequest(wq),
        .host_reset_pin_n(host_reset_pin_n), .core_msr(core_msr),
        .core_int(core_int), .core_head_unload_done(core_head_unload_done),
        .core_fifo_rdata(core_fifo_rdata), .core_wdata_n(core_wdata_n),
        .core_wgate_n(core_wgate_n), .core_step_n(core_step_n),
        .core_dir_n(core_dir_n), .core_hdsel_n(core_hdsel_n),
        .core_reset(core_reset), .core_fifo_rd(core_fifo_rd),
        .core_fifo_wr(core_fifo_wr), .core_fifo_wdata(core_fifo_wdata),
        .core_rate(core_rate), .core_clk_en(core_clk_en),
        .core_powered_down(core_powered_down),
        .motor_on_out_n(motor_on_out_n), .motor_on_oe(motor_on_oe),
        .drive_select_out_n(drive_select_out_n),
        .drive_select_oe(drive_select_oe),
        .write_stream_out_n(write_stream_out_n),
        .write_stream_oe(write_stream_oe),
        .write_gate_out_n(write_gate_out_n), .write_gate_oe(write_gate_oe),
        .step_direction_out_n(step_direction_out_n),
        .step_pulse_out_n(step_pulse_out_n),
        .head_side_out_n(head_side_out_n),
        .density_select_out(density_select_out),
        .read_stream_in_n(read_stream_in_n),
        .write_protect_in_n(write_protect_in_n),
        .track_zero_in_n(track_zero_in_n),
        .index_pulse_in_n(index_pulse_in_n),
        .disk_change_in_n(disk_change_in_n));

    fdcpw_host_model host (.clk(clk), .avs_address(adr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be),
        .avs_readdata(rdd), .avs_waitrequest(wq));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // ****************
    // helpers
    // ****************
    task automatic chk(input string nm, input logic [7:0] s, e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        host.xfer(i, 1'b1, d, v);
    endtask
    task automatic rd(input logic [3:0] i, input logic [7:0] e,
                      input string nm);
        host.xfer(i, 1'b0, 8'h00, v);
        chk(nm, v, e);
    endtask
    task automatic pd_is(input string nm, input logic e);
        repeat (2) @(posedge clk);
        chk(nm, {7'h00, core_powered_down}, {7'h00, e});
    endtask
    task automatic sleep();
        int n;
        n = 0;
        while (core_powered_down !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("enters sleep", {7'h00, core_powered_down}, 8'h01);
    endtask
    task automatic summarize();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #50000;
        n_fail++;
        summarize();
    end

    // ****************
    // tests
    // ****************
    initial begin
        n_fail = 0;
        checked = 0;
        arst_n = 1'b0;
        host_reset_pin_n = 1'b1;
        core_msr = 8'h80;
        core_int = 1'b0;
        core_head_unload_done = 1'b1;
        core_fifo_rdata = 8'h5a;
        {core_wdata_n, core_wgate_n, core_step_n} = 3'h7;
        {core_dir_n, core_hdsel_n, read_stream_in_n} = 3'h7;
        {write_protect_in_n, track_zero_in_n} = 2'h0;
        {index_pulse_in_n, disk_change_in_n} = 2'h3;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk("reset rate", {6'h00, core_rate}, 8'h02);
        wr(`FDCPW_IDX_DOC, 8'h04);
        wr(`FDCPW_IDX_PWR, 8'h01);
        pd_is("awake before timer", 1'b0);
        sleep();
        rd(`FDCPW_IDX_PWR, 8'h03, "auto state");
        chk("drive oe", {4'h0, motor_on_oe, drive_select_oe,
            write_stream_oe, write_gate_oe}, 8'h00);
        core_step_n <= 1'b0;
        core_dir_n <= 1'b0;
        core_hdsel_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("active pins", {3'h0, step_pulse_out_n, step_direction_out_n,
            head_side_out_n, density_select_out}, 8'h02);
        rd(`FDCPW_IDX_STA, 8'h05, "status a asleep");
        rd(`FDCPW_IDX_DOC, 8'h04, "output ctrl asleep");
        $display("test entry done");
        for (int i = 0; i < 6; i++) begin
            case (i)
                0: host.xfer(`FDCPW_IDX_STA, 1'b0, 8'h00, v);
                1: host.xfer(`FDCPW_IDX_STB, 1'b0, 8'h00, v);
                2: host.xfer(`FDCPW_IDX_DOC, 1'b0, 8'h00, v);
                3: wr(`FDCPW_IDX_DOC, 8'h04);
                4: host.xfer(`FDCPW_IDX_DIS, 1'b0, 8'h00, v);
                default: wr(`FDCPW_IDX_CFG, 8'h01);
            endcase
            pd_is("stays asleep", 1'b1);
            chk("clock gated", {7'h00, core_clk_en}, 8'h00);
        end
        chk("rate held", {6'h00, core_rate}, 8'h02);
        rd(4'h3, 8'h00, "unmapped");
        $display("test asleep access done");
        rd(`FDCPW_IDX_MST, 8'h80, "main status");
        pd_is("msr wakes", 1'b0);
        chk("rate applied", {6'h00, core_rate}, 8'h01);
        chk("no reinit", {7'h00, core_reset}, 8'h00);
        repeat (12) @(posedge clk);
        chk("timer restart", {7'h00, core_powered_down}, 8'h00);
        sleep();
        $display("test msr wake done");
        for (int i = 0; i < 3; i++) begin
            sleep();
            if (i == 0) begin
                rd(`FDCPW_IDX_FIFO, 8'h5a, "fifo read");
                @(posedge clk);
                chk("fifo pop", {7'h00, core_fifo_rd}, 8'h01);
            end else if (i == 1) begin
                wr(`FDCPW_IDX_FIFO, 8'ha5);
                @(posedge clk);
                chk("fifo write", core_fifo_wdata, 8'ha5);
                chk("fifo strobe", {7'h00, core_fifo_wr}, 8'h01);
            end else begin
                wr(`FDCPW_IDX_DOC, 8'h14);
            end
            pd_is("access wakes", 1'b0);
        end
        chk("motor pin", {6'h00, motor_on_oe, motor_on_out_n},
            8'h02);
        chk("select pin", {6'h00, drive_select_oe, drive_select_out_n},
            8'h02);
        chk("write pins", {6'h00, write_stream_out_n, write_gate_out_n},
            8'h03);
        wr(`FDCPW_IDX_DOC, 8'h04);
        core_int <= 1'b1;
        repeat (30) @(posedge clk);
        chk("int blocks sleep", {7'h00, core_powered_down}, 8'h00);
        core_int <= 1'b0;
        $display("test wake sources done");
        sleep();
        wr(`FDCPW_IDX_RSC, 8'h42);
        rd(`FDCPW_IDX_PWR, 8'h05, "rate powerdown");
        host.xfer(`FDCPW_IDX_MST, 1'b0, 8'h00, v);
        pd_is("rate pd holds", 1'b1);
        host_reset_pin_n <= 1'b0;
        repeat (2) @(posedge clk);
        host_reset_pin_n <= 1'b1;
        pd_is("hard reset wakes", 1'b0);
        chk("core reset", {7'h00, core_reset}, 8'h01);
        wr(`FDCPW_IDX_DOC, 8'h04);
        wr(`FDCPW_IDX_PWR, 8'h01);
        sleep();
        wr(`FDCPW_IDX_RSC, 8'h82);
        pd_is("soft reset wakes", 1'b0);
        wr(`FDCPW_IDX_DOC, 8'h04);
        sleep();
        wr(`FDCPW_IDX_DOC, 8'h00);
        pd_is("reset bit wakes", 1'b0);
        chk("core held", {7'h00, core_reset}, 8'h01);
        $display("test resets done");
        chk("bus stalls", host.n_stall[7:0], 8'h00);
        summarize();
    end
endmodule
